// ===== bench/uart_status_and_data_port_tb.sv
`timescale 1ns/1ns
`include "usdp_defs.vh"
module uart_status_and_data_port_tb;
   localparam int Bit = `USDP_TICK_DIV * `USDP_OVS;
   logic clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, rxdPin, txdPin, irq;
   int n_fail = 0, total_checks = 0;
   usdp_top usdp_top_inst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxdPin(rxdPin), .txdPin(txdPin), .irq(irq));
   usdp_serial_peer usdp_serial_peer_inst (.clock(clock), .serIn(txdPin), .serOut(rxdPin));
   initial forever #4 clock = ~clock;
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         n_fail++;
         conclude();
      end
      @(posedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, d, r, e);
   endtask
   task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 32'h0, r, e);
      chk(what, exp, r);
   endtask
   task automatic rxCase(input logic [7:0] d, input logic [7:0] xd, input logic noisy,
                         input logic badPar, input logic stop, input logic [31:0] st);
      usdp_serial_peer_inst.send(d, badPar, ~^d, stop, noisy);
      rd("rx status", `USDP_ADDR_STATUS, st);
      rd("rx data", `USDP_ADDR_DATA, {24'h0, xd});
      wr(`USDP_ADDR_CLEAR, 32'hff);
   endtask
   task automatic testReset;
      logic [31:0] r;
      logic e;
      rd("status", `USDP_ADDR_STATUS, 32'h0);
      rd("data", `USDP_ADDR_DATA, 32'h0);
      wr(`USDP_ADDR_STATUS, 32'hff);
      rd("status ro", `USDP_ADDR_STATUS, 32'h0);
      apb(1'h0, 12'h3fc, 32'h0, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      $display("test reset done");
   endtask
   task automatic testTx;
      int n;
      wr(`USDP_ADDR_DATA, 32'h5a);
      wr(`USDP_ADDR_DATA, 32'h3c);
      rd("tx busy", `USDP_ADDR_STATUS, 32'h0);
      for (n = 0; usdp_serial_peer_inst.got.size() < 2 && n < 30000; n++) @(posedge clock);
      if (n >= 30000) begin
         n_fail++;
         conclude();
      end
      repeat (Bit) @(posedge clock);
      chk("tx byte0", 32'h5a, {24'h0, usdp_serial_peer_inst.got[0]});
      chk("tx byte1", 32'h3c, {24'h0, usdp_serial_peer_inst.got[1]});
      rd("tx idle", `USDP_ADDR_STATUS, 32'hc0);
      rd("rd not tx", `USDP_ADDR_DATA, 32'h0);
      wr(`USDP_ADDR_CLEAR, 32'h0);
      rd("clr zero", `USDP_ADDR_STATUS, 32'hc0);
      wr(`USDP_ADDR_CLEAR, 32'h40);
      rd("clr one", `USDP_ADDR_STATUS, 32'h80);
      wr(`USDP_ADDR_CLEAR, 32'h80);
      $display("test tx done");
   endtask
   task automatic testRx;
      wr(`USDP_ADDR_MASK, 32'h20);
      usdp_serial_peer_inst.send(8'h96, 1'h0, 1'h0, 1'h1, 1'h0);
      rd("rx full", `USDP_ADDR_STATUS, 32'h20);
      chk("irq on", 32'h1, {31'h0, irq});
      repeat (10 * Bit) @(posedge clock);
      rd("idle", `USDP_ADDR_STATUS, 32'h30);
      wr(`USDP_ADDR_MASK, 32'h0);
      @(posedge clock);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`USDP_ADDR_CLEAR, 32'h20);
      rxCase(8'h96, 8'h96, 1'h0, 1'h0, 1'h1, 32'h30);
      usdp_serial_peer_inst.send(8'h11, 1'h0, 1'h0, 1'h1, 1'h0);
      rxCase(8'h22, 8'h11, 1'h0, 1'h0, 1'h1, 32'h28);
      $display("test rx done");
   endtask
   task automatic testErrors;
      rxCase(8'h4b, 8'h4b, 1'h1, 1'h0, 1'h1, 32'h24);
      wr(`USDP_ADDR_CTRL, 32'h1);
      rxCase(8'hc3, 8'hc3, 1'h0, 1'h1, 1'h0, 32'h23);
      $display("test errors done");
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      @(posedge clock);
      testReset();
      testTx();
      testRx();
      testErrors();
      conclude();
   end
   initial begin
      repeat (120000) @(posedge clock);
      n_fail++;
      conclude();
   end
endmodule

// ===== bench/usdp_serial_peer.sv
`timescale 1ns/1ns
`include "usdp_defs.vh"
module usdp_serial_peer (
   input wire clock, // core clock
   input wire serIn, // line from the block
   output logic serOut // line to the block
);
   localparam int Bit = `USDP_TICK_DIV * `USDP_OVS;
   logic [7:0] got[$];
   initial serOut = 1'h1;
   // noisy puts a short opposite pulse across the centre of data bit 3
   task automatic send(input logic [7:0] d, input logic parOn, input logic parBit,
                       input logic stop, input logic noisy);
      logic [10:0] f;
      f = {stop, parBit, d, 1'h0};
      if (!parOn) f[9] = stop;
      for (int i = 0; i < (parOn ? 11 : 10); i++) begin
         serOut <= f[i];
         // pulse spans one oversample tick, so exactly one centre sample sees it
         repeat (Bit / 2 - 33) @(posedge clock);
         if (noisy && i == 4) serOut <= !f[i];
         repeat (`USDP_TICK_DIV) @(posedge clock);
         serOut <= f[i];
         repeat (Bit - Bit / 2 + 33 - `USDP_TICK_DIV) @(posedge clock);
      end
      serOut <= 1'h1;
      repeat (Bit) @(posedge clock);
   endtask
   initial forever begin
      logic [7:0] b;
      @(negedge serIn);
      repeat (Bit + Bit / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         b[i] = serIn;
         repeat (Bit) @(posedge clock);
      end
      got.push_back(b);
   end
endmodule

// ===== bench/usdp_top_assertions.sv
`timescale 1ns/1ns
`include "usdp_defs.vh"
module usdp_top_assertions (
   input wire clock, // core clock
   input wire rst_n, // async reset, low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb address
   input wire [31:0] pwdata, // apb write data
   input wire [31:0] prdata, // apb read data
   input wire pready, // apb ready
   input wire pslverr, // apb error
   input wire rxdPin, // serial in
   input wire txdPin, // serial out
   input wire irq // interrupt
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   wire mapped = paddr == `USDP_ADDR_STATUS || paddr == `USDP_ADDR_DATA ||
      paddr == `USDP_ADDR_CLEAR || paddr == `USDP_ADDR_MASK || paddr == `USDP_ADDR_CTRL;
   wire done = psel && penable && pready;
   property p_answer; psel && !penable |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no ready after setup");
   property p_stand; pready |=> !pready; endproperty
   a_stand: assert property (p_stand) else $error("ready held");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_upper; done && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_unmap; done && !pwrite && !mapped |-> pslverr && prdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
   property p_clr; done && !pwrite && paddr == `USDP_ADDR_CLEAR |-> prdata == 32'h0; endproperty
   a_clr: assert property (p_clr) else $error("clear reg read nonzero");
   property p_mask;
      done && pwrite && paddr == `USDP_ADDR_MASK && pwdata[7:0] == 8'h00 |-> ##2 !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("irq with mask zero");
   property p_start; $fell(txdPin) |-> !txdPin[*8]; endproperty
   a_start: assert property (p_start) else $error("short start bit");
endmodule
bind usdp_top usdp_top_assertions usdp_top_assertions_inst (.clock(clock), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxdPin(rxdPin), .txdPin(txdPin),
   .irq(irq));

// ===== hdl/usdp_defs.vh
`ifndef USDP_DEFS_VH
`define USDP_DEFS_VH
// register byte addresses (printed offsets are indices; byte address = 4 * index)
`define USDP_IDX_STATUS 8'hc8
`define USDP_IDX_DATA 8'hc9
`define USDP_IDX_CLEAR 8'hd8
`define USDP_IDX_MASK 8'he0
`define USDP_IDX_CTRL 8'he1
`define USDP_ADDR_STATUS 12'h320
`define USDP_ADDR_DATA 12'h324
`define USDP_ADDR_CLEAR 12'h360
`define USDP_ADDR_MASK 12'h380
`define USDP_ADDR_CTRL 12'h384
// status bit positions
`define USDP_B_TXEMPTY 7
`define USDP_B_TXDONE 6
`define USDP_B_RXFULL 5
`define USDP_B_IDLE 4
`define USDP_B_OVERRUN 3
`define USDP_B_NOISE 2
`define USDP_B_FRAME 1
`define USDP_B_PARITY 0
// ctrl bit positions
`define USDP_C_PAREN 0
`define USDP_C_PARODD 1
// reset values
`define USDP_RST_DATA 8'h00
`define USDP_RST_MASK 8'h00
`define USDP_RST_CTRL 8'h00
// timing: bit rate and oversampling
`define USDP_CLK_HZ 125000000
`define USDP_BAUD 115200
`define USDP_OVS 16
`define USDP_TICK_DIV (`USDP_CLK_HZ / (`USDP_BAUD * `USDP_OVS))
`define USDP_IDLE_BITS 10
`endif

// ===== hdl/usdp_rx.v
`timescale 1ns/1ns
`include "usdp_defs.vh"
module usdp_rx (
   input wire clock, // core clock
   input wire rst_n, // async reset, low
   input wire tick, // oversample enable
   input wire rxd, // synchronised serial in
   input wire parEn, // parity enable
   input wire parOdd, // odd parity
   output reg done_q, // one-cycle character complete
   output reg [7:0] data_q, // received byte
   output reg noise_q, // samples disagreed
   output reg frame_q, // bad stop bit
   output reg parity_q, // parity mismatch
   output reg idle_q // one-cycle idle line found
);
   reg busy_q;
   reg [3:0] ovs_q;
   reg [3:0] bitIdx_q;
   reg [9:0] shift_q;
   reg [2:0] smp_q;
   reg noisy_q;
   reg [7:0] idleCnt_q;
   reg idleArm_q;
   wire majority = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
   wire [3:0] lastIdx = parEn ? 4'ha : 4'h9;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         ovs_q <= 4'h0;
         bitIdx_q <= 4'h0;
         shift_q <= 10'h000;
         smp_q <= 3'h7;
         noisy_q <= 1'b0;
         done_q <= 1'b0;
         data_q <= 8'h00;
         noise_q <= 1'b0;
         frame_q <= 1'b0;
         parity_q <= 1'b0;
         idle_q <= 1'b0;
         idleCnt_q <= 8'h00;
         idleArm_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         idle_q <= 1'b0;
         if (tick) begin
            if (!busy_q) begin
               if (rxd) begin
                  // idle: ten bit times (USDP_IDLE_BITS) of mark after activity
                  if (idleArm_q) begin
                     idleCnt_q <= idleCnt_q + 8'h01;
                     if (idleCnt_q == `USDP_IDLE_BITS * `USDP_OVS - 1) begin
                        idle_q <= 1'b1;
                        idleArm_q <= 1'b0;
                     end
                  end
               end else begin
                  busy_q <= 1'b1;
                  ovs_q <= 4'h0;
                  bitIdx_q <= 4'h0;
                  noisy_q <= 1'b0;
                  idleCnt_q <= 8'h00;
               end
            end else begin
               ovs_q <= ovs_q + 4'h1;
               if (ovs_q >= 4'h7 && ovs_q <= 4'h9) begin
                  smp_q <= {smp_q[1:0], rxd};
               end
               if (ovs_q == 4'ha) begin
                  if (!(smp_q == 3'h0 || smp_q == 3'h7)) begin
                     noisy_q <= 1'b1;
                  end
                  shift_q <= {majority, shift_q[9:1]};
                  if (bitIdx_q == 4'h0 && majority) begin
                     busy_q <= 1'b0; // false start
                  end else if (bitIdx_q == lastIdx) begin
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     idleArm_q <= 1'b1;
                     noise_q <= noisy_q | !(smp_q == 3'h0 || smp_q == 3'h7);
                     frame_q <= !majority;
                  end
                  bitIdx_q <= bitIdx_q + 4'h1;
               end
               if (ovs_q == 4'hf) begin
                  ovs_q <= 4'h0;
               end
            end
         end
         // shifter now holds stop in bit 9; with parity the start bit has fallen out
         if (done_q && parEn) begin
            data_q <= shift_q[7:0];
            parity_q <= (^shift_q[8:0]) ^ parOdd;
         end else if (done_q) begin
            data_q <= shift_q[8:1];
            parity_q <= 1'b0;
         end
      end
   end
endmodule

// ===== hdl/usdp_top.v
// Function
// - bit7 set when transmit holding buffer empties
// - bit6 set when transmitter goes fully idle
// - bit5 set when a character is received
// - bit4 set on idle line
// - bit3 set when character lost
// - bit2 set on noisy reception
// - bit1 set on bad stop bit
// - bit0 set on parity mismatch
// - data reads receive, writes transmit buffer
// - flags cleared by writing one; bits 7 and 6 also by a data write
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "usdp_defs.vh"
module usdp_top (
   input wire clock, // core clock, 125 MHz
   input wire rst_n, // async reset, low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   input wire rxdPin, // serial input
   output reg txdPin, // serial output
   output reg irq // interrupt, high
);
   reg rxMeta_q;
   reg rxSync_q;
   reg [15:0] divCnt_q;
   reg tick_q;
   reg [7:0] txHold_q;
   reg txHoldFull_q;
   reg [7:0] rxBuf_q;
   reg [7:0] flags_q;
   reg [7:0] mask_q;
   reg [7:0] ctrl_q;
   wire txBusy;
   wire txSerial;
   wire rxDone;
   wire [7:0] rxData;
   wire rxNoise;
   wire rxFrame;
   wire rxParity;
   wire rxIdle;
   reg rxDoneDly_q;
   reg txBusyDly_q;
   wire txDoneEdge = txBusyDly_q && !txBusy;

   function known;
      input [11:0] a;
      begin
         known = (a == `USDP_ADDR_STATUS) || (a == `USDP_ADDR_DATA) ||
                 (a == `USDP_ADDR_CLEAR) || (a == `USDP_ADDR_MASK) ||
                 (a == `USDP_ADDR_CTRL);
      end
   endfunction

   wire access = psel && penable && pready;
   wire wrEn = access && pwrite && known(paddr);
   wire rdEn = access && !pwrite && known(paddr);
   wire wrData = wrEn && (paddr == `USDP_ADDR_DATA);
   wire wrClear = wrEn && (paddr == `USDP_ADDR_CLEAR);
   wire [7:0] clrBits = wrClear ? pwdata[7:0] : 8'h00;
   wire shiftLoad = txHoldFull_q && !txBusy;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rxMeta_q <= 1'b1;
         rxSync_q <= 1'b1;
      end else begin
         rxMeta_q <= rxdPin;
         rxSync_q <= rxMeta_q;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (divCnt_q == `USDP_TICK_DIV - 1) begin
         divCnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   usdp_tx usdp_tx_inst (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick_q),
      .load(shiftLoad),
      .loadData(txHold_q),
      .parEn(ctrl_q[`USDP_C_PAREN]),
      .parOdd(ctrl_q[`USDP_C_PARODD]),
      .busy_q(txBusy),
      .txd_q(txSerial)
   );

   usdp_rx usdp_rx_inst (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick_q),
      .rxd(rxSync_q),
      .parEn(ctrl_q[`USDP_C_PAREN]),
      .parOdd(ctrl_q[`USDP_C_PARODD]),
      .done_q(rxDone),
      .data_q(rxData),
      .noise_q(rxNoise),
      .frame_q(rxFrame),
      .parity_q(rxParity),
      .idle_q(rxIdle)
   );

   // receive data settles one cycle after done; act on the delayed pulse
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rxDoneDly_q <= 1'b0;
      end else begin
         rxDoneDly_q <= rxDone;
      end
   end

   // transmit holding buffer
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         txHold_q <= `USDP_RST_DATA;
         txHoldFull_q <= 1'b0;
      end else if (wrData) begin
         txHold_q <= pwdata[7:0];
         txHoldFull_q <= 1'b1;
      end else if (shiftLoad) begin
         txHoldFull_q <= 1'b0;
      end
   end

   // event flags: hardware set wins over write-one clear
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= 8'h00;
         rxBuf_q <= `USDP_RST_DATA;
      end else begin
         flags_q <= flags_q & ~clrBits;
         if (shiftLoad) begin
            flags_q[`USDP_B_TXEMPTY] <= 1'b1;
         end
         if (wrData) begin
            flags_q[`USDP_B_TXEMPTY] <= 1'b0;
            flags_q[`USDP_B_TXDONE] <= 1'b0;
         end
         if (!txBusy && !txHoldFull_q && !wrData && txDoneEdge) begin
            flags_q[`USDP_B_TXDONE] <= 1'b1;
         end
         if (rxIdle) begin
            flags_q[`USDP_B_IDLE] <= 1'b1;
         end
         if (rxDoneDly_q) begin
            if (flags_q[`USDP_B_RXFULL] && !clrBits[`USDP_B_RXFULL]) begin
               flags_q[`USDP_B_OVERRUN] <= 1'b1;
            end else begin
               rxBuf_q <= rxData;
               flags_q[`USDP_B_RXFULL] <= 1'b1;
               flags_q[`USDP_B_NOISE] <= rxNoise | (flags_q[`USDP_B_NOISE] & ~clrBits[2]);
               flags_q[`USDP_B_FRAME] <= rxFrame | (flags_q[`USDP_B_FRAME] & ~clrBits[1]);
               flags_q[`USDP_B_PARITY] <= rxParity | (flags_q[0] & ~clrBits[0]);
            end
         end
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         txBusyDly_q <= 1'b0;
      end else begin
         txBusyDly_q <= txBusy;
      end
   end

   // mask and control registers
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= `USDP_RST_MASK;
         ctrl_q <= `USDP_RST_CTRL;
      end else if (wrEn) begin
         if (paddr == `USDP_ADDR_MASK) begin
            mask_q <= pwdata[7:0];
         end
         if (paddr == `USDP_ADDR_CTRL) begin
            ctrl_q <= pwdata[7:0];
         end
      end
   end

   // apb slave: no wait state, ready in first access cycle
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known(paddr);
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `USDP_ADDR_STATUS: prdata <= {24'h000000, flags_q};
               `USDP_ADDR_DATA: prdata <= {24'h000000, rxBuf_q};
               `USDP_ADDR_MASK: prdata <= {24'h000000, mask_q};
               `USDP_ADDR_CTRL: prdata <= {24'h000000, ctrl_q};
               default: prdata <= 32'h00000000;
            endcase
         end else if (!psel) begin
            prdata <= 32'h00000000;
         end
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         txdPin <= 1'b1;
         irq <= 1'b0;
      end else begin
         txdPin <= txSerial;
         irq <= |(flags_q & mask_q);
      end
   end
endmodule

// ===== hdl/usdp_tx.v
`timescale 1ns/1ns
`include "usdp_defs.vh"
module usdp_tx (
   input wire clock, // core clock
   input wire rst_n, // async reset, low
   input wire tick, // oversample enable
   input wire load, // take byte from holding buffer
   input wire [7:0] loadData, // byte to send
   input wire parEn, // parity enable
   input wire parOdd, // odd parity
   output reg busy_q, // shifter working
   output reg txd_q // serial out
);
   reg [10:0] shift_q;
   reg [3:0] bitCnt_q;
   reg [3:0] ovs_q;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= 11'h7ff;
         bitCnt_q <= 4'h0;
         ovs_q <= 4'h0;
         busy_q <= 1'b0;
         txd_q <= 1'b1;
      end else if (!busy_q) begin
         txd_q <= 1'b1;
         if (load) begin
            shift_q <= {1'b1, parEn ? ((^loadData) ^ parOdd) : 1'b1, loadData, 1'b0};
            bitCnt_q <= parEn ? 4'hb : 4'ha;
            ovs_q <= 4'h0;
            busy_q <= 1'b1;
         end
      end else if (tick) begin
         txd_q <= shift_q[0];
         ovs_q <= ovs_q + 4'h1;
         if (ovs_q == 4'hf) begin
            shift_q <= {1'b1, shift_q[10:1]};
            bitCnt_q <= bitCnt_q - 4'h1;
            if (bitCnt_q == 4'h1) begin
               busy_q <= 1'b0;
            end
         end
      end
   end
endmodule
